// File: psdg_chk_assertions.sv
// Port checker for psdg_top, bound below.
// Assumes the register offsets and reset values of the map header.
module psdg_chk (
	input logic        mclk_i,
	input logic        nrst_i,
	input logic        tip_sense_i,
	input logic        ring_sense_i,
	input logic        bo_below_trip_i,
	input logic        bo_above_recover_i,
	input logic [7:0]  addr_i,
	input logic [15:0] wdata_i,
	input logic        wr_i,
	input logic        rd_i,
	input logic [15:0] rdata_o,
	input logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctrl_q;
	logic [4:0] mask_q;
	logic       rd_q, rd_st_q, rd_hi_q;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	// Mirrors of the registers the checks depend on
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q <= 8'h01;
			mask_q <= 5'h1F;
			rd_q <= 1'b0;
			rd_st_q <= 1'b0;
			rd_hi_q <= 1'b0;
		end else begin
			if (wr_i && addr_i == 8'h00) ctrl_q <= wdata_i[7:0];
			if (wr_i && addr_i == 8'h14) mask_q <= wdata_i[4:0];
			rd_q <= rd_i;
			rd_st_q <= rd_i && addr_i == 8'h0C;
			rd_hi_q <= rd_i && addr_i > 8'h14;
		end
	end
	property p_idle;
		!rd_q |-> rdata_o == 16'h0000;
	endproperty
	a_idle: assert property (p_idle)
		else $error("rdata not idle");
	property p_unmapped;
		rd_hi_q |-> rdata_o == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped");
	property p_code;
		rd_st_q |-> rdata_o[15:5] == 11'h000 && (rdata_o[1] || !rdata_o[0])
			&& (rdata_o[3] || !rdata_o[2]);
	endproperty
	a_code: assert property (p_code)
		else $error("pair code");
	property p_pdn;
		rd_st_q && $past(ctrl_q[0], 2) && $past(ctrl_q[0], 3)
			|-> rdata_o[3:0] == 4'h0;
	endproperty
	a_pdn: assert property (p_pdn)
		else $error("filter off");
	property p_bo_off;
		rd_st_q && !$past(ctrl_q[7], 2) && !$past(ctrl_q[7], 3) |-> !rdata_o[4];
	endproperty
	a_bo_off: assert property (p_bo_off)
		else $error("monitor off");
	// Gating is combinational: the read sees the control of the cycle before
	property p_gate;
		rd_st_q && $past(ctrl_q[6]) && $past(ctrl_q[6], 2)
			|-> !(rdata_o[0] && rdata_o[2]);
	endproperty
	a_gate: assert property (p_gate)
		else $error("gating");
	property p_masked;
		irq_o |-> $past(mask_q) != 5'h1F;
	endproperty
	a_masked: assert property (p_masked)
		else $error("irq masked");
	property p_mask_wr;
		wr_i && addr_i == 8'h14 && wdata_i[4:0] == 5'h1F |=> ##1 !irq_o;
	endproperty
	a_mask_wr: assert property (p_mask_wr)
		else $error("irq mask");
	c_status: cover property (rd_i && addr_i == 8'h0C);
	c_irq: cover property ($rose(irq_o));
	c_gate: cover property (rd_st_q && ctrl_q[6]);
endmodule

bind psdg_top psdg_chk i_chk (.*);

// File: psdg_jack.sv
// Jack and supply model driving the sense comparators and the monitor.
// Assumes the bench calls its tasks; levels change just after an edge.
module psdg_jack (
	input  logic mclk_i,
	output logic tip_sense_o,
	output logic ring_sense_o,
	output logic bo_below_o,
	output logic bo_above_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-ups hold both sense lines high with no plug
	initial begin
		tip_sense_o = 1'b1;
		ring_sense_o = 1'b1;
		bo_below_o = 1'b0;
		bo_above_o = 1'b1;
	end
	task put(input logic t, r);
		@(posedge mclk_i);
		tip_sense_o <= t;
		ring_sense_o <= r;
	endtask
	task supply(input logic b, a);
		@(posedge mclk_i);
		bo_below_o <= b;
		bo_above_o <= a;
	endtask
endmodule

// File: psdg_map.vh
// Register map, field positions, reset values and timing for the plug-sense
// debounce gate. Assumes 16-bit registers on a plain strobe port.
`ifndef PSDG_MAP_VH
`define PSDG_MAP_VH

// Clock and debounce tick
`define PSDG_CLK_PERIOD_NS   50
`define PSDG_TICK_NS         1000000
`define PSDG_TICK_CYCLES     (`PSDG_TICK_NS / `PSDG_CLK_PERIOD_NS)

// Register offsets
`define PSDG_ADDR_W          8
`define PSDG_DATA_W          16
`define PSDG_OFF_CTRL        8'h00
`define PSDG_OFF_TIME        8'h04
`define PSDG_OFF_TIME_EXTRA  8'h08
`define PSDG_OFF_STATUS      8'h0C
`define PSDG_OFF_INT_STAT    8'h10
`define PSDG_OFF_INT_MASK    8'h14

// Control register fields
`define PSDG_CTRL_PDN        0
`define PSDG_CTRL_LATCH      1
`define PSDG_CTRL_RING_PU    2
`define PSDG_CTRL_TIPC_LO    3
`define PSDG_CTRL_TIPC_HI    4
`define PSDG_CTRL_INV        5
`define PSDG_CTRL_GATE       6
`define PSDG_CTRL_BO_PU      7
`define PSDG_CTRL_W          8
`define PSDG_CTRL_RST        8'h01

// Debounce time fields, in ticks
`define PSDG_TIME_RST        16'h2222
`define PSDG_EXTRA_RST       4'h2

// Status and interrupt bits
`define PSDG_ST_TIP_PLUG     0
`define PSDG_ST_TIP_UNPLUG   1
`define PSDG_ST_RING_PLUG    2
`define PSDG_ST_RING_UNPLUG  3
`define PSDG_ST_BROWNOUT     4
`define PSDG_IRQ_W           5
`define PSDG_MASK_RST        5'h1F

`endif

// File: psdg_top.v
// Plug-sense debounce gate: tip and ring debounce, combo-jack gating,
// brown-out trip hold, sticky interrupt events and the register port.
// Assumes sense and monitor inputs already synchronous to mclk_i.
`include "psdg_map.vh"

module psdg_top #(
	parameter TICK_CYCLES = `PSDG_TICK_CYCLES,
	parameter TIME_W      = 4
) (
	// Clock and reset
	input  wire                    mclk_i,
	input  wire                    nrst_i,
	// Sense comparators and supply monitor
	input  wire                    tip_sense_i,
	input  wire                    ring_sense_i,
	input  wire                    bo_below_trip_i,
	input  wire                    bo_above_recover_i,
	// Register port
	input  wire [`PSDG_ADDR_W-1:0] addr_i,
	input  wire [`PSDG_DATA_W-1:0] wdata_i,
	input  wire                    wr_i,
	input  wire                    rd_i,
	output reg  [`PSDG_DATA_W-1:0] rdata_o,
	// Interrupt
	output reg                     irq_o
);

	localparam DIV_W = $clog2(TICK_CYCLES + 1);
	localparam CNT_W = TIME_W + 1;
	localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam [31:0]      DIV_FULL = TICK_CYCLES - 1;
	localparam [DIV_W-1:0] DIV_LAST = DIV_FULL[DIV_W-1:0];

	reg  [`PSDG_CTRL_W-1:0] ctrl_q;
	reg  [4*TIME_W-1:0]     time_q;
	reg  [TIME_W-1:0]       extra_q;
	reg  [`PSDG_IRQ_W-1:0]  int_stat_q;
	reg  [`PSDG_IRQ_W-1:0]  int_stat_d;
	reg  [`PSDG_IRQ_W-1:0]  int_mask_q;
	reg  [DIV_W-1:0]        div_q;
	reg                     tick_q;
	reg                     brownout_trip_status_q;
	reg  [2:0]              prev_q;
	reg  [`PSDG_DATA_W-1:0] rdata_d;
	reg                     irq_d;

	wire global_power_down         = ctrl_q[`PSDG_CTRL_PDN];
	wire analog_control_latch      = ctrl_q[`PSDG_CTRL_LATCH];
	wire ring_debounce_power_up    = ctrl_q[`PSDG_CTRL_RING_PU];
	wire tip_ctrl_lo               = ctrl_q[`PSDG_CTRL_TIPC_LO];
	wire tip_config_invert         = ctrl_q[`PSDG_CTRL_INV];
	wire combo_jack_gating         = ctrl_q[`PSDG_CTRL_GATE];
	wire brownout_monitor_power_up = ctrl_q[`PSDG_CTRL_BO_PU];

	wire wr_ctrl  = wr_i && (addr_i == `PSDG_OFF_CTRL);
	wire wr_time  = wr_i && (addr_i == `PSDG_OFF_TIME);
	wire wr_extra = wr_i && (addr_i == `PSDG_OFF_TIME_EXTRA);
	wire wr_istat = wr_i && (addr_i == `PSDG_OFF_INT_STAT);
	wire wr_imask = wr_i && (addr_i == `PSDG_OFF_INT_MASK);

	// Debounce tick divider
	// Ticks run free, so a debounce lasts between n-1 and n ticks
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_q  <= {DIV_W{1'b0}};
			tick_q <= 1'b0;
		end else if (div_q == DIV_LAST) begin
			div_q  <= {DIV_W{1'b0}};
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
			tick_q <= 1'b0;
		end
	end

	// Control and time registers
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q  <= `PSDG_CTRL_RST;
			time_q  <= `PSDG_TIME_RST;
			extra_q <= `PSDG_EXTRA_RST;
		end else begin
			if (wr_ctrl)
				ctrl_q <= wdata_i[`PSDG_CTRL_W-1:0];
			if (wr_time)
				time_q <= wdata_i[4*TIME_W-1:0];
			if (wr_extra)
				extra_q <= wdata_i[TIME_W-1:0];
		end
	end

	// Channel 0 tip, channel 1 ring; low level means inserted, on tip only while tip_config_invert is clear
	wire [1:0] det_w;
	wire [1:0] en_w;
	wire [1:0] plug_w;
	wire [1:0] unplug_w;
	assign det_w[0] = ~tip_sense_i ^ tip_config_invert;
	assign det_w[1] = ~ring_sense_i;
	// Tip control 01 or 11 enables the tip filter
	assign en_w[0] = ~global_power_down & analog_control_latch & tip_ctrl_lo;
	assign en_w[1] = ~global_power_down & ring_debounce_power_up;

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_chan
			reg              lvl_q;
			reg  [CNT_W-1:0] cnt_q;
			reg              plug_q;
			reg              unplug_q;
			wire [TIME_W-1:0] rise_t = time_q[2*i*TIME_W +: TIME_W];
			wire [TIME_W-1:0] fall_t = time_q[(2*i+1)*TIME_W +: TIME_W];
			// Only the tip path has the extra removal setting
			wire [TIME_W-1:0] ext_t  = (i == 0) ? extra_q : {TIME_W{1'b0}};
			// Zero times mean one tick, so a status never flips on raw level
			wire [CNT_W-1:0] rise_n = (rise_t == {TIME_W{1'b0}}) ?
				CNT_ONE : {1'b0, rise_t};
			wire [CNT_W-1:0] fall_n = (fall_t == {TIME_W{1'b0}}) ?
				CNT_ONE : {1'b0, fall_t};
			wire [CNT_W-1:0] rem_n  = fall_n + {1'b0, ext_t};

			always @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					lvl_q    <= 1'b0;
					cnt_q    <= {CNT_W{1'b0}};
					plug_q   <= 1'b0;
					unplug_q <= 1'b0;
				end else if (!en_w[i]) begin
					lvl_q    <= 1'b0;
					cnt_q    <= {CNT_W{1'b0}};
					plug_q   <= 1'b0;
					unplug_q <= 1'b0;
				end else if (det_w[i] != lvl_q) begin
					lvl_q <= det_w[i];
					cnt_q <= {CNT_W{1'b0}};
				end else begin
					// Saturate so a long-stable level never wraps
					if (tick_q && cnt_q != CNT_MAX)
						cnt_q <= cnt_q + CNT_ONE;
					// Unplug sets no later than plug and clears no earlier: 01 never shows
					if (lvl_q) begin
						if (cnt_q >= CNT_ONE)
							unplug_q <= 1'b1;
						if (cnt_q >= rise_n)
							plug_q <= 1'b1;
					end else begin
						if (cnt_q >= fall_n)
							plug_q <= 1'b0;
						if (cnt_q >= rem_n)
							unplug_q <= 1'b0;
					end
				end
			end

			assign plug_w[i]   = plug_q;
			assign unplug_w[i] = unplug_q;
		end
	endgenerate

	// Combo-jack gating on the debounced detected states
	reg  tip_plug_debounced;
	reg  ring_plug_debounced;
	wire tip_unplug_debounced  = unplug_w[0];
	wire ring_unplug_debounced = unplug_w[1];
	always @* begin
		tip_plug_debounced  = plug_w[0];
		ring_plug_debounced = plug_w[1];
		if (combo_jack_gating) begin
			case ({plug_w[0], plug_w[1]})
				2'h0: begin
					tip_plug_debounced  = 1'b0;
					ring_plug_debounced = 1'b0;
				end
				2'h1: begin
					// Lone ring may be an empty jack seen as optical
					tip_plug_debounced  = 1'b0;
					ring_plug_debounced = 1'b0;
				end
				2'h2: begin
					tip_plug_debounced  = 1'b1;
					ring_plug_debounced = 1'b0;
				end
				2'h3: begin
					// Metal tip of an optical plug is no headphone
					tip_plug_debounced  = 1'b0;
					ring_plug_debounced = 1'b1;
				end
				default: begin
					tip_plug_debounced  = 1'b0;
					ring_plug_debounced = 1'b0;
				end
			endcase
		end
	end

	// Brown-out trip: set below trip, held until recovered
	// Trip has priority, so a dip is never lost to the recover input
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			brownout_trip_status_q <= 1'b0;
		else if (!brownout_monitor_power_up)
			brownout_trip_status_q <= 1'b0;
		else if (bo_below_trip_i)
			brownout_trip_status_q <= 1'b1;
		else if (bo_above_recover_i)
			brownout_trip_status_q <= 1'b0;
	end

	wire [`PSDG_IRQ_W-1:0] status_w;
	assign status_w[`PSDG_ST_TIP_PLUG]    = tip_plug_debounced;
	assign status_w[`PSDG_ST_TIP_UNPLUG]  = tip_unplug_debounced;
	assign status_w[`PSDG_ST_RING_PLUG]   = ring_plug_debounced;
	assign status_w[`PSDG_ST_RING_UNPLUG] = ring_unplug_debounced;
	assign status_w[`PSDG_ST_BROWNOUT]    = brownout_trip_status_q;

	// Events: insert, remove, brown-out trip
	wire [`PSDG_IRQ_W-1:0] event_w;
	assign event_w[0] = tip_plug_debounced & ~prev_q[0];
	assign event_w[1] = ~tip_plug_debounced & prev_q[0];
	assign event_w[2] = ring_plug_debounced & ~prev_q[1];
	assign event_w[3] = ~ring_plug_debounced & prev_q[1];
	assign event_w[4] = brownout_trip_status_q & ~prev_q[2];

	// Set wins over a write-one clear in the same cycle
	always @* begin
		int_stat_d = int_stat_q;
		if (wr_istat)
			int_stat_d = int_stat_d & ~wdata_i[`PSDG_IRQ_W-1:0];
		int_stat_d = int_stat_d | event_w;
	end

	// A fresh mask applies from the cycle after its write
	always @* begin
		irq_d = |(int_stat_d & ~int_mask_q);
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev_q     <= 3'h0;
			int_stat_q <= {`PSDG_IRQ_W{1'b0}};
			int_mask_q <= `PSDG_MASK_RST;
			irq_o      <= 1'b0;
		end else begin
			prev_q <= {brownout_trip_status_q, ring_plug_debounced,
				tip_plug_debounced};
			int_stat_q <= int_stat_d;
			if (wr_imask)
				int_mask_q <= wdata_i[`PSDG_IRQ_W-1:0];
			// Masks default set, so no interrupt while supplies ramp
			irq_o <= irq_d;
		end
	end

	// Read mux; status is live, never latched
	always @* begin
		rdata_d = {`PSDG_DATA_W{1'b0}};
		case (addr_i)
			`PSDG_OFF_CTRL:
				rdata_d[`PSDG_CTRL_W-1:0] = ctrl_q;
			`PSDG_OFF_TIME:
				rdata_d[4*TIME_W-1:0] = time_q;
			`PSDG_OFF_TIME_EXTRA:
				rdata_d[TIME_W-1:0] = extra_q;
			`PSDG_OFF_STATUS:
				rdata_d[`PSDG_IRQ_W-1:0] = status_w;
			`PSDG_OFF_INT_STAT:
				rdata_d[`PSDG_IRQ_W-1:0] = int_stat_q;
			`PSDG_OFF_INT_MASK:
				rdata_d[`PSDG_IRQ_W-1:0] = int_mask_q;
			default:
				rdata_d = {`PSDG_DATA_W{1'b0}};
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_o <= {`PSDG_DATA_W{1'b0}};
		else if (rd_i)
			rdata_o <= rdata_d;
		else
			rdata_o <= {`PSDG_DATA_W{1'b0}};
	end

endmodule

// File: tb.sv
// Self-checking bench for the plug-sense debounce gate.
// Assumes psdg_top and the jack model; a short tick keeps the run brief.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        tip_sense_i, ring_sense_i;
	logic        bo_below_trip_i, bo_above_recover_i;
	logic [15:0] rdata_o;
	logic        irq_o;
	int          fails = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [15:0] rv[7] = '{16'h0001, 16'h2222, 16'h0002, 16'h0000,
		16'h0000, 16'h001F, 16'h0000};
	always #25 mclk_i = ~mclk_i;
	psdg_jack i_jack (.mclk_i(mclk_i), .tip_sense_o(tip_sense_i),
		.ring_sense_o(ring_sense_i), .bo_below_o(bo_below_trip_i),
		.bo_above_o(bo_above_recover_i));
	psdg_top #(.TICK_CYCLES(4)) i_dut (.*);
	task summarize;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 22000) begin
			fails++;
			summarize;
		end
	end
	// Tick of 4 clocks; tip rise 5, fall 2, extra 3; ring rise and fall 1
	initial begin
		w(12);
		nrst_i <= 1'b1;
		w(20000);
		foreach (ra[i]) rd(ra[i], rv[i]);
		wr(8'h04, 16'h1125);
		wr(8'h08, 16'h0003);
		wr(8'h00, 16'h0000);
		wr(8'h00, 16'h0002);
		wr(8'h00, 16'h0006);
		wr(8'h00, 16'h000E);
		rd(8'h0C, 16'h0000);
		i_jack.put(0, 1);
		w(6);
		i_jack.put(1, 1);
		w(2);
		i_jack.put(0, 1);
		w(10);
		rd(8'h0C, 16'h0002);
		w(30);
		rd(8'h0C, 16'h0003);
		wr(8'h14, 16'h001E);
		w(3);
		// Look after the edge, once the flop has settled
		#1 chk(16'(irq_o), 16'h0001);
		wr(8'h10, 16'h0001);
		w(3);
		#1 chk(16'(irq_o), 16'h0000);
		wr(8'h14, 16'h001F);
		i_jack.put(1, 1);
		w(12);
		rd(8'h0C, 16'h0002);
		w(30);
		rd(8'h0C, 16'h0000);
		i_jack.put(0, 0);
		w(40);
		rd(8'h0C, 16'h000F);
		wr(8'h00, 16'h004E);
		w(3);
		rd(8'h0C, 16'h000E);
		i_jack.put(1, 0);
		w(40);
		rd(8'h0C, 16'h0008);
		wr(8'h00, 16'h000E);
		w(3);
		rd(8'h0C, 16'h000C);
		wr(8'h00, 16'h002E);
		w(40);
		rd(8'h0C, 16'h000F);
		i_jack.supply(1, 0);
		w(3);
		rd(8'h0C, 16'h000F);
		wr(8'h00, 16'h00AE);
		w(3);
		rd(8'h0C, 16'h001F);
		i_jack.supply(0, 0);
		w(3);
		rd(8'h0C, 16'h001F);
		i_jack.supply(0, 1);
		w(3);
		rd(8'h0C, 16'h000F);
		wr(8'h14, 16'h000F);
		w(3);
		#1 chk(16'(irq_o), 16'h0001);
		// Ring removal with its one-tick fall time; tip stays in
		i_jack.put(1, 1);
		w(20);
		rd(8'h0C, 16'h0003);
		summarize;
	end
endmodule
